// file: rtl/icra_ctl_if.sv
/*
  Carrier between the instruction path and the control register file.
  Assumes both ends sit on the same processor clock.
*/
`timescale 1ns/1ps
interface icra_ctl_if;
  import icra_pkg::*;

  logic                   ptr_load;
  logic [ICRA_SEL_W-1:0]  ptr_next;
  logic [ICRA_SEL_W-1:0]  ptr;
  logic [ICRA_SEL_W-1:0]  rd_sel;
  logic [ICRA_DATA_W-1:0] rd_data;
  logic                   wr_en;
  logic [ICRA_SEL_W-1:0]  wr_sel;
  logic [ICRA_DATA_W-1:0] wr_data;
  logic                   done_load;
  logic [ICRA_STAT_W-1:0] done_status;
  logic [ICRA_DATA_W-1:0] done_rdata;
  logic [ICRA_SLOT_W-1:0] slot;
  logic [ICRA_DATA_W-1:0] wdata;

  modport regs (
    input  ptr_load, ptr_next, rd_sel, wr_en, wr_sel, wr_data,
    input  done_load, done_status, done_rdata,
    output ptr, rd_data, slot, wdata
  );
  modport core (
    output ptr_load, ptr_next, rd_sel, wr_en, wr_sel, wr_data,
    output done_load, done_status, done_rdata,
    input  ptr, rd_data, slot, wdata
  );
endinterface : icra_ctl_if

// file: rtl/icra_ctl_regs.sv
/*
  Control register file of the memory controller: select pointer,
  slot status, adaptor result and adaptor value registers.
  Assumes single-cycle write strobes from the instruction path.
*/
`timescale 1ns/1ps
module icra_ctl_regs
  import icra_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  icra_ctl_if.regs  ctl
);

  logic [ICRA_SEL_W-1:0]  ptr_reg;
  logic [ICRA_DATA_W-1:0] status_reg;
  logic [ICRA_DATA_W-1:0] result_reg;
  logic [ICRA_DATA_W-1:0] value_reg;

  ////////////////////////////////////////////////////////////////////
  // Decode and next values
  wire                   wr_status = ctl.wr_en && ctl.wr_sel == ICRA_SEL_STATUS;
  wire                   wr_result = ctl.wr_en && ctl.wr_sel == ICRA_SEL_RESULT;
  wire                   wr_value  = ctl.wr_en && ctl.wr_sel == ICRA_SEL_VALUE;
  wire [ICRA_DATA_W-1:0] slot_mask = {{(ICRA_DATA_W-ICRA_SLOT_W){1'b0}},
                                      {ICRA_SLOT_W{1'b1}}} << ICRA_SLOT_LSB;
  wire [ICRA_DATA_W-1:0] stat_mask = {{(ICRA_DATA_W-ICRA_STAT_W){1'b0}},
                                      {ICRA_STAT_W{1'b1}}} << ICRA_STAT_LSB;
  wire [ICRA_DATA_W-1:0] stat_ins  = {{(ICRA_DATA_W-ICRA_STAT_W){1'b0}},
                                      ctl.done_status} << ICRA_STAT_LSB;
  wire [ICRA_DATA_W-1:0] status_sw = wr_status ? (ctl.wr_data & (slot_mask | stat_mask))
                                               : status_reg;
  // Completion wins over a software write of the status field
  wire [ICRA_DATA_W-1:0] status_next = ctl.done_load ? ((status_sw & ~stat_mask) | stat_ins)
                                                     : status_sw;
  wire [ICRA_DATA_W-1:0] result_next = ctl.done_load ? ctl.done_rdata
                                     : wr_result ? ctl.wr_data : result_reg;
  wire [ICRA_DATA_W-1:0] value_next  = wr_value ? ctl.wr_data : value_reg;
  wire [ICRA_SEL_W-1:0]  ptr_next    = ctl.ptr_load ? ctl.ptr_next : ptr_reg;

  ////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_reg    <= ICRA_SEL_RST;
      status_reg <= ICRA_DATA_RST;
      result_reg <= ICRA_DATA_RST;
      value_reg  <= ICRA_DATA_RST;
    end else begin
      ptr_reg    <= ptr_next;
      status_reg <= status_next;
      result_reg <= result_next;
      value_reg  <= value_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read side; unknown selects read as zero
  assign ctl.ptr     = ptr_reg;
  assign ctl.rd_data = (ctl.rd_sel == ICRA_SEL_STATUS) ? status_reg
                     : (ctl.rd_sel == ICRA_SEL_RESULT) ? result_reg
                     : (ctl.rd_sel == ICRA_SEL_VALUE)  ? value_reg
                     : ICRA_DATA_RST;
  assign ctl.slot    = status_reg[ICRA_SLOT_LSB +: ICRA_SLOT_W];
  assign ctl.wdata   = value_reg;

endmodule : icra_ctl_regs

// file: rtl/icra_pkg.sv
/*
  Shared constants and types for the I/O control register access path.
  Assumes one processor clock and an active-low asynchronous reset.
*/
package icra_pkg;

  localparam int unsigned ICRA_DATA_W = 32;
  localparam int unsigned ICRA_SEL_W  = 6;
  localparam int unsigned ICRA_SLOT_W = 4;
  localparam int unsigned ICRA_STAT_W = 8;
  localparam int unsigned ICRA_FUNC_W = 16;
  localparam int unsigned ICRA_GPR_W  = 6;

  // Function codes of the special instructions
  localparam logic [ICRA_FUNC_W-1:0] ICRA_FUNC_CTL_FETCH = 16'h0080;
  localparam logic [ICRA_FUNC_W-1:0] ICRA_FUNC_CTL_STORE = 16'h00C0;
  localparam logic [ICRA_FUNC_W-1:0] ICRA_FUNC_ADP_FETCH = 16'h0300;
  localparam logic [ICRA_FUNC_W-1:0] ICRA_FUNC_ADP_STORE = 16'h0340;

  // Control register select codes
  localparam logic [ICRA_SEL_W-1:0] ICRA_SEL_STATUS = 6'h00;
  localparam logic [ICRA_SEL_W-1:0] ICRA_SEL_RESULT = 6'h01;
  localparam logic [ICRA_SEL_W-1:0] ICRA_SEL_VALUE  = 6'h02;

  // Status register layout: slot in the low bits, operation status above
  localparam int unsigned ICRA_SLOT_LSB = 0;
  localparam int unsigned ICRA_STAT_LSB = 8;

  // Values after reset
  localparam logic [ICRA_SEL_W-1:0]  ICRA_SEL_RST  = 6'h00;
  localparam logic [ICRA_DATA_W-1:0] ICRA_DATA_RST = 32'h00000000;

  typedef enum logic [1:0] {
    ICRA_IDLE = 2'b01,
    ICRA_WAIT = 2'b10
  } icra_state_t;

endpackage : icra_pkg

// file: rtl/io_control_register_access.sv
/*
  Processor-side I/O instruction path with the memory controller's
  control registers and the adaptor request handshake.
  Assumes the pipeline holds the instruction at its first stage while
  stall_out is high, and adaptor logic on the same clock.
*/
`timescale 1ns/1ps
module io_control_register_access
  import icra_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   instr_valid_in,
  input  wire logic                   instr_special_in,
  input  wire logic [ICRA_FUNC_W-1:0] instr_func_in,
  input  wire logic [ICRA_SEL_W-1:0]  ctl_select_field_in,
  input  wire logic [ICRA_GPR_W-1:0]  target_gpr_in,
  input  wire logic [ICRA_DATA_W-1:0] result_latch_in,
  input  wire logic                   adp_done_in,
  input  wire logic [ICRA_STAT_W-1:0] adp_status_in,
  input  wire logic [ICRA_DATA_W-1:0] adp_rdata_in,
  output logic                        stall_out,
  output logic                        gpr_we_out,
  output logic [ICRA_GPR_W-1:0]       gpr_waddr_out,
  output logic [ICRA_DATA_W-1:0]      gpr_wdata_out,
  output logic                        adp_req_out,
  output logic                        adp_write_out,
  output logic [ICRA_SLOT_W-1:0]      adp_slot_out,
  output logic [ICRA_DATA_W-1:0]      adp_addr_out,
  output logic [ICRA_DATA_W-1:0]      adp_wdata_out
);

  icra_ctl_if ctl ();

  icra_ctl_regs u_regs (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .ctl      (ctl)
  );

  icra_state_t            state_reg;
  icra_state_t            state_next;
  logic [ICRA_DATA_W-1:0] ctl_read_latch_reg;
  logic [ICRA_SEL_W-1:0]  ex_sel_reg;
  logic [ICRA_GPR_W-1:0]  ex_gpr_reg;
  logic                   ex_fetch_reg;
  logic                   ex_store_reg;
  logic                   ex_adp_fetch_reg;
  logic                   ex_adp_store_reg;

  ////////////////////////////////////////////////////////////////////
  // First stage decode
  wire in_wait        = state_reg == ICRA_WAIT;
  wire do_take        = instr_valid_in && state_reg == ICRA_IDLE;
  wire do_special     = do_take && instr_special_in;
  wire is_ctl_fetch   = instr_func_in == ICRA_FUNC_CTL_FETCH;
  wire is_ctl_store   = instr_func_in == ICRA_FUNC_CTL_STORE;
  wire is_adp_fetch   = instr_func_in == ICRA_FUNC_ADP_FETCH;
  wire is_adp_store   = instr_func_in == ICRA_FUNC_ADP_STORE;
  // Status waits on any pending op, result data only on a pending read
  wire hazard         = adp_req_out && (ctl.ptr == ICRA_SEL_STATUS ||
                        (ctl.ptr == ICRA_SEL_RESULT && !adp_write_out));
  wire enter_wait     = do_special && is_ctl_fetch && hazard;
  wire fetch_go       = (do_special && is_ctl_fetch && !hazard) ||
                        (in_wait && !adp_req_out);
  wire adp_done       = adp_req_out && adp_done_in;
  wire launch         = (ex_adp_fetch_reg || ex_adp_store_reg) && !adp_req_out;
  wire [ICRA_SEL_W-1:0] ex_sel_next = do_special ? ctl.ptr : ex_sel_reg;
  wire [ICRA_GPR_W-1:0] ex_gpr_next = do_take ? target_gpr_in : ex_gpr_reg;

  assign ctl.ptr_load    = do_special;
  assign ctl.ptr_next    = ctl_select_field_in;
  // While waiting the old pointer is already replaced, so read the saved one
  assign ctl.rd_sel      = in_wait ? ex_sel_reg : ctl.ptr;
  assign ctl.wr_en       = ex_store_reg;
  assign ctl.wr_sel      = ex_sel_reg;
  assign ctl.wr_data     = result_latch_in;
  assign ctl.done_load   = adp_done;
  assign ctl.done_status = adp_status_in;
  assign ctl.done_rdata  = adp_rdata_in;

  assign state_next = enter_wait ? ICRA_WAIT
                    : (in_wait && !adp_req_out) ? ICRA_IDLE : state_reg;

  ////////////////////////////////////////////////////////////////////
  // Pipeline and stall
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg          <= ICRA_IDLE;
      stall_out          <= 1'b0;
      ctl_read_latch_reg <= ICRA_DATA_RST;
      ex_sel_reg         <= ICRA_SEL_RST;
      ex_gpr_reg         <= '0;
      ex_fetch_reg       <= 1'b0;
      ex_store_reg       <= 1'b0;
      ex_adp_fetch_reg   <= 1'b0;
      ex_adp_store_reg   <= 1'b0;
    end else begin
      state_reg          <= state_next;
      stall_out          <= state_next == ICRA_WAIT;
      ctl_read_latch_reg <= fetch_go ? ctl.rd_data : ctl_read_latch_reg;
      ex_sel_reg         <= ex_sel_next;
      ex_gpr_reg         <= ex_gpr_next;
      ex_fetch_reg       <= fetch_go;
      ex_store_reg       <= do_special && is_ctl_store;
      ex_adp_fetch_reg   <= do_special && is_adp_fetch;
      ex_adp_store_reg   <= do_special && is_adp_store;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Third stage: target register write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gpr_we_out    <= 1'b0;
      gpr_waddr_out <= '0;
      gpr_wdata_out <= ICRA_DATA_RST;
    end else begin
      gpr_we_out    <= ex_fetch_reg;
      gpr_waddr_out <= ex_gpr_reg;
      gpr_wdata_out <= ctl_read_latch_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Adaptor request, held until the controller reports completion.
  // A launch while busy is dropped: software keeps I/O ops apart.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      adp_req_out   <= 1'b0;
      adp_write_out <= 1'b0;
      adp_slot_out  <= '0;
      adp_addr_out  <= ICRA_DATA_RST;
      adp_wdata_out <= ICRA_DATA_RST;
    end else if (launch) begin
      adp_req_out   <= 1'b1;
      adp_write_out <= ex_adp_store_reg;
      adp_slot_out  <= ctl.slot;
      adp_addr_out  <= result_latch_in;
      adp_wdata_out <= ctl.wdata;
    end else if (adp_done) begin
      adp_req_out   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  fetch_data_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_special && is_ctl_fetch && !hazard) |->
      ##2 (gpr_we_out && gpr_wdata_out == $past(ctl.rd_data, 2)))
    else $error("control fetch returned wrong data");

  pointer_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    do_special |=> ctl.ptr == $past(ctl_select_field_in))
    else $error("select pointer not replaced");

  any_special_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_special && !is_ctl_fetch && !is_ctl_store) |=>
      ctl.ptr == $past(ctl_select_field_in))
    else $error("non I/O special did not move pointer");

  store_path_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_special && is_ctl_store) |=>
      (ctl.wr_en && ctl.wr_sel == $past(ctl.ptr) && ctl.wr_data == result_latch_in))
    else $error("control store missed its register");

  adaptor_addr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    launch |=> (adp_req_out && adp_addr_out == $past(result_latch_in)))
    else $error("adaptor address not from result latch");

  slot_route_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    launch |=> (adp_slot_out == $past(ctl.slot) &&
      (!adp_write_out || adp_wdata_out == $past(ctl.wdata))))
    else $error("adaptor op misrouted");

  read_stall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_special && is_ctl_fetch && adp_req_out && !adp_write_out &&
     ctl.ptr == ICRA_SEL_RESULT) |=> stall_out)
    else $error("result fetch did not stall");

  write_stall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (do_special && is_ctl_fetch && adp_req_out && ctl.ptr == ICRA_SEL_STATUS)
      |=> stall_out)
    else $error("status fetch did not stall");

  request_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (adp_req_out && !adp_done_in) |=> adp_req_out)
    else $error("adaptor request dropped early");

  stall_release_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stall_out && !adp_req_out) |-> ##[1:2] !stall_out)
    else $error("stall held after completion");

  wait_fetch_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (in_wait && !adp_req_out) |->
      ##2 (gpr_we_out && gpr_wdata_out == $past(ctl.rd_data, 2)))
    else $error("stalled fetch returned wrong data");

  idle_no_stall_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!adp_req_out && !in_wait) |=> !stall_out)
    else $error("stall raised with nothing pending");

  wait_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (in_wait && adp_req_out) |=> stall_out)
    else $error("stall dropped before completion");

endmodule : io_control_register_access

// file: verif/icra_adaptor_model.sv
/*
  Adaptor logic on the far side of the request handshake.
  Assumes one processor clock; latency is set by the bench per operation.
*/
`timescale 1ns/1ps
module icra_adaptor_model
  import icra_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic                   req_in,
  input  wire logic [ICRA_DATA_W-1:0] addr_in,
  input  wire logic [7:0]             lat_in,
  output logic                        done_out,
  output logic [ICRA_STAT_W-1:0]      status_out,
  output logic [ICRA_DATA_W-1:0]      rdata_out
);
  logic [7:0]  cnt_reg;
  logic        done_reg;
  logic [39:0] last_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_reg  <= 8'h00;
      done_reg <= 1'b0;
      last_reg <= 40'h0;
    end else begin
      cnt_reg  <= req_in ? cnt_reg + 8'h01 : 8'h00;
      done_reg <= req_in && !done_reg && (cnt_reg == lat_in);
      if (done_reg) begin
        last_reg <= {status_out, rdata_out};
      end
    end
  end

  // Outside the pulse the lines show the inverse, so stale data never matches
  assign done_out   = done_reg;
  assign status_out = done_reg ? addr_in[7:0] : ~last_reg[39:32];
  assign rdata_out  = done_reg ? ~addr_in : ~last_reg[31:0];
endmodule : icra_adaptor_model

// file: verif/io_control_register_access_tb.sv
/*
  Self-checking bench for the I/O control register access path.
  Assumes the adaptor model answers each request lat+1 cycles after it is raised.
*/
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end
module io_control_register_access_tb;
  import icra_pkg::*;
  logic clk_in = 0, rst_n_in = 0, valid = 0, special = 0, done;
  logic [15:0] func = 16'h0;
  logic [5:0]  sel = 6'h0, gpr = 6'h0;
  logic [31:0] rl = 32'h0, rdata, gwd, aaddr, awd;
  logic [7:0]  st, lat = 8'h01;
  logic stall, gwe, areq, awr;
  logic [5:0] gwa;
  logic [3:0] aslot;
  int num_errors = 0, comparisons = 0;

  always #2.5 clk_in = ~clk_in;

  io_control_register_access u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .instr_valid_in(valid), .instr_special_in(special), .instr_func_in(func),
    .ctl_select_field_in(sel), .target_gpr_in(gpr), .result_latch_in(rl),
    .adp_done_in(done), .adp_status_in(st), .adp_rdata_in(rdata), .stall_out(stall),
    .gpr_we_out(gwe), .gpr_waddr_out(gwa), .gpr_wdata_out(gwd), .adp_req_out(areq),
    .adp_write_out(awr), .adp_slot_out(aslot), .adp_addr_out(aaddr), .adp_wdata_out(awd));

  icra_adaptor_model u_adp (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(areq),
    .addr_in(aaddr), .lat_in(lat), .done_out(done), .status_out(st), .rdata_out(rdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input logic s, input logic [15:0] f, input logic [5:0] se,
                     input logic [31:0] r);
    valid = 1; special = s; func = f; sel = se; rl = r;
    @(posedge clk_in); #1;
  endtask : cyc

  // Non-I/O filler keeps I/O instructions apart
  task automatic idle(input int n);
    repeat (n) cyc(0, 16'h0, 6'h0, 32'h3C3C_0F0F);
  endtask : idle

  // The filler after a fetch is held while stalled and taken once stall_out drops
  task automatic fetch(input logic [5:0] se, input logic [31:0] exp, input logic exp_st);
    logic seen;
    int k;
    seen = 0;
    k = 0;
    gpr = se ^ 6'h15;
    cyc(1, ICRA_FUNC_CTL_FETCH, se, 32'h0);
    special = 0;
    func = 16'h0;
    sel = 6'h0;
    rl = 32'h3C3C_0F0F;
    while (gwe !== 1'b1 && k < 80) begin
      if (stall === 1'b1) seen = 1;
      @(posedge clk_in); #1;
      k++;
    end
    `CHK(gwe, 1'b1, "fetch write pulse")
    `CHK(gwd, exp, "fetch data")
    `CHK(gwa, se ^ 6'h15, "fetch target")
    `CHK(seen, exp_st, "fetch stall")
    `CHK(areq, 1'b0, "request released")
    idle(1);
    `CHK(gwe, 1'b0, "fetch pulse length")
    idle(1);
  endtask : fetch

  task automatic store(input logic [5:0] se, input logic [31:0] v);
    cyc(1, ICRA_FUNC_CTL_STORE, se, v);
    cyc(0, 16'h0, 6'h0, v);
    idle(2);
  endtask : store

  task automatic adp(input logic w, input logic [5:0] se, input logic [31:0] a,
                     input logic [31:0] wd);
    cyc(1, w ? ICRA_FUNC_ADP_STORE : ICRA_FUNC_ADP_FETCH, se, a);
    cyc(0, 16'h0, 6'h0, a);
    `CHK(areq, 1'b1, "adaptor request")
    `CHK(awr, w, "adaptor direction")
    `CHK(aaddr, a, "adaptor address")
    `CHK(aslot, 4'h5, "adaptor slot")
    if (w) `CHK(awd, wd, "adaptor write data")
  endtask : adp

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_ctl;
    fetch(ICRA_SEL_STATUS, 32'h0, 0);
    store(ICRA_SEL_STATUS, 32'hFFFF_FF05);
    fetch(ICRA_SEL_STATUS, 32'h0000_FF05, 0);
    fetch(ICRA_SEL_VALUE, 32'h0000_FF05, 0);
    store(ICRA_SEL_VALUE, 32'hC3C3_1234);
    fetch(ICRA_SEL_VALUE, 32'hC3C3_1234, 0);
    cyc(1, 16'h0241, ICRA_SEL_STATUS, 32'h0);
    idle(2);
    fetch(ICRA_SEL_VALUE, 32'h0000_FF05, 0);
    fetch(6'h3F, 32'hC3C3_1234, 0);
    store(6'h3F, 32'hFFFF_FFFF);
    fetch(ICRA_SEL_STATUS, 32'h0, 0);
    fetch(ICRA_SEL_RESULT, 32'h0000_FF05, 0);
    store(ICRA_SEL_RESULT, 32'h5A5A_0001);
    fetch(ICRA_SEL_STATUS, 32'h5A5A_0001, 0);
  endtask : t_ctl

  task automatic t_read;
    lat = 8'd25;
    adp(0, ICRA_SEL_STATUS, 32'h1234_56A7, 32'h0);
    fetch(ICRA_SEL_STATUS, 32'h0000_A705, 1);
    fetch(ICRA_SEL_RESULT, 32'h0000_A705, 0);
    fetch(ICRA_SEL_RESULT, ~32'h1234_56A7, 0);
    lat = 8'd3;
    adp(0, ICRA_SEL_RESULT, 32'h0BAD_F00D, 32'h0);
    fetch(ICRA_SEL_RESULT, ~32'h0BAD_F00D, 1);
  endtask : t_read

  task automatic t_write;
    lat = 8'd9;
    fetch(ICRA_SEL_VALUE, ~32'h0BAD_F00D, 0);
    store(ICRA_SEL_STATUS, 32'h8765_4321);
    adp(1, ICRA_SEL_STATUS, 32'h0000_0042, 32'h8765_4321);
    fetch(ICRA_SEL_STATUS, 32'h0000_4205, 1);
  endtask : t_write

  task automatic summarize;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    #(5.0 * 6000);
    num_errors++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    `CHK({stall, gwe, areq}, 3'b000, "outputs in reset")
    rst_n_in = 1;
    // No interrupt source here, so I/O sequences always run unbroken
    t_ctl();
    t_read();
    t_write();
    summarize();
  end
endmodule : io_control_register_access_tb
